// ===== sim/pif_flags_tb.sv
// self-checking bench for the event flag block
`timescale 1ns/1ns
module pif_flags_tb import pif_pkg::*;;
   typedef struct packed {
      logic [11:0] conv;
      logic [1:0] tw_meas;
      logic [7:0] top;
      logic [7:0] c01;
      logic [7:0] c23;
   } pif_tb_row_s;
   localparam pif_tb_row_s ROWS [10] = '{
      {12'h001, 2'h0, 8'h10, 8'h01, 8'h00}, {12'h100, 2'h0, 8'h10, 8'h04, 8'h00},
      {12'h002, 2'h0, 8'h20, 8'h10, 8'h00}, {12'h200, 2'h0, 8'h20, 8'h40, 8'h00},
      {12'h004, 2'h0, 8'h40, 8'h00, 8'h01}, {12'h400, 2'h0, 8'h40, 8'h00, 8'h04},
      {12'h008, 2'h0, 8'h80, 8'h00, 8'h10}, {12'h800, 2'h0, 8'h80, 8'h00, 8'h40},
      {12'h000, 2'h2, 8'h04, 8'h00, 8'h00}, {12'h000, 2'h1, 8'h01, 8'h00, 8'h00}};
   // roughly forty-five times the expected run length
   localparam int TB_TIMEOUT = 30000;

   logic clock;
   logic rst_b;
   pif_pins_s pins;
   logic [3:0] conv_en_req;
   logic meas_done;
   pif_reg_req_s reg_req;
   logic [7:0] reg_rdata;
   logic [3:0] conv_en;
   logic startup_busy;
   logic [7:0] rd;
   int error_cnt = 0;
   int total_checks = 0;

   pif_flags #(.SC_TIMEOUT_CYC(20), .STARTUP_CYC(8)) dut (.clock(clock), .rst_b(rst_b), .pins(pins),
      .conv_en_req(conv_en_req), .meas_done(meas_done), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .conv_en(conv_en), .startup_busy(startup_busy));
   pif_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));

   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_ctl(input string name, input logic [3:0] exp, input logic [3:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
      host.reg_read(addr, rd);
      chk_reg(name, exp, rd);
   endtask

   // bounded wait for the end of startup
   task automatic wait_run();
      for (int n = 0; n < 200 && startup_busy !== 1'h0; n++) begin
         @(posedge clock);
      end
      chk_ctl("startup_busy", 4'h0, {3'h0, startup_busy});
   endtask

   // causes: 0 software reset, 1 reset pin, 2 supply undervoltage
   task automatic reset_cause(input int k);
      host.ack_all();
      meas_done <= 1'h1;
      tick(1);
      meas_done <= 1'h0;
      tick(2);
      rdchk("top_before_cause", PIF_ADDR_TOP, 8'h01);
      if (k == 0) begin
         host.reg_write(PIF_ADDR_RESET, 8'h01);
      end else if (k == 1) begin
         pins.reset_pin_n <= 1'h0;
      end else begin
         pins.analog_supply_ok <= 1'h0;
      end
      tick(4);
      chk_ctl("busy_in_hold", 4'h1, {3'h0, startup_busy});
      chk_ctl("conv_en_in_hold", 4'h0, conv_en);
      pins.reset_pin_n <= 1'h1;
      pins.analog_supply_ok <= 1'h1;
      wait_run();
      rdchk("top_after_cause", PIF_ADDR_TOP, 8'h02);
   endtask

   initial begin
      rst_b = 1'h0;
      pins = '0;
      pins.reset_pin_n = 1'h1;
      pins.analog_supply_ok = 1'h1;
      conv_en_req = 4'h0;
      meas_done = 1'h0;
      tick(16);
      chk_ctl("busy_reset", 4'h1, {3'h0, startup_busy});
      chk_ctl("conv_en_reset", 4'h0, conv_en);
      rst_b <= 1'h1;
      wait_run();
      rdchk("top_startup", PIF_ADDR_TOP, 8'h02);
      rdchk("c01_default", PIF_ADDR_C01, 8'h00);
      rdchk("c23_default", PIF_ADDR_C23, 8'h00);
      host.reg_write(PIF_ADDR_TOP, 8'h00);
      rdchk("top_write_zero", PIF_ADDR_TOP, 8'h02);
      host.reg_write(PIF_ADDR_TOP, 8'h02);
      rdchk("top_write_one", PIF_ADDR_TOP, 8'h00);
      rdchk("reset_reg_read", PIF_ADDR_RESET, 8'h00);
      host.reg_write(8'h20, 8'hff);
      rdchk("unmapped", 8'h20, 8'h00);
      host.reg_write(PIF_ADDR_STAT, 8'hff);
      rdchk("status_ro", PIF_ADDR_STAT, 8'h00);
      foreach (ROWS[i]) begin
         pins.conv <= ROWS[i].conv;
         pins.twarn <= ROWS[i].tw_meas[1];
         meas_done <= ROWS[i].tw_meas[0];
         tick(1);
         meas_done <= 1'h0;
         tick(4);
         pins.conv <= '0;
         pins.twarn <= 1'h0;
         tick(3);
         rdchk("row_top", PIF_ADDR_TOP, ROWS[i].top);
         rdchk("row_c01", PIF_ADDR_C01, ROWS[i].c01);
         rdchk("row_c23", PIF_ADDR_C23, ROWS[i].c23);
         host.ack_all();
         rdchk("row_cleared", PIF_ADDR_TOP, 8'h00);
      end
      conv_en_req <= 4'hf;
      pins.conv.above_sc <= 4'hf;
      tick(4);
      chk_ctl("conv_en_on", 4'hf, conv_en);
      pins.tsd <= 1'h1;
      tick(4);
      chk_ctl("conv_en_tsd", 4'h0, conv_en);
      rdchk("live_tsd", PIF_ADDR_STAT, 8'h02);
      pins.tsd <= 1'h0;
      tick(4);
      chk_ctl("conv_en_refused", 4'h0, conv_en);
      rdchk("live_cool", PIF_ADDR_STAT, 8'h00);
      rdchk("top_tsd", PIF_ADDR_TOP, 8'h08);
      host.reg_write(PIF_ADDR_TOP, 8'h08);
      tick(3);
      chk_ctl("conv_en_back", 4'hf, conv_en);
      pins.conv.above_sc[0] <= 1'h0;
      tick(4);
      rdchk("c01_short_run", PIF_ADDR_C01, 8'h02);
      rdchk("top_summary", PIF_ADDR_TOP, 8'h10);
      conv_en_req <= 4'h0;
      tick(2);
      pins.conv.above_sc <= 4'h0;
      tick(2);
      host.ack_all();
      rdchk("top_clear", PIF_ADDR_TOP, 8'h00);
      conv_en_req <= 4'h2;
      tick(10);
      rdchk("c01_before_timeout", PIF_ADDR_C01, 8'h00);
      tick(20);
      rdchk("c01_timeout", PIF_ADDR_C01, 8'h20);
      conv_en_req <= 4'h0;
      tick(3);
      host.ack_all();
      pins.conv.ilim <= 4'h1;
      tick(4);
      host.reg_write(PIF_ADDR_C01, 8'h01);
      rdchk("c01_persist", PIF_ADDR_C01, 8'h01);
      pins.conv.ilim <= 4'h0;
      tick(3);
      host.reg_write(PIF_ADDR_C01, 8'h00);
      rdchk("c01_zero_write", PIF_ADDR_C01, 8'h01);
      host.reg_write(PIF_ADDR_C01, 8'h01);
      rdchk("c01_one_write", PIF_ADDR_C01, 8'h00);
      conv_en_req <= 4'hf;
      pins.conv.above_sc <= 4'hf;
      for (int k = 0; k < 3; k++) begin
         reset_cause(k);
      end
      final_report();
   end

   initial begin
      tick(TB_TIMEOUT);
      error_cnt++;
      $display("[FAIL] watchdog expected done seen hang");
      final_report();
   end
endmodule

// ===== sim/pif_host_model.sv
// host processor model on the register port of the event flag block
`timescale 1ns/1ns
module pif_host_model import pif_pkg::*; (
   // clock
   input wire logic clock,
   // register port
   output pif_reg_req_s reg_req,
   input wire logic [7:0] reg_rdata
);
   initial reg_req = '0;

   // a released request shows inverted address and data so stale values are never taken as live
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock);
      reg_req <= {addr, data, 1'h1, 1'h0};
      @(posedge clock);
      reg_req <= {~addr, ~data, 1'h0, 1'h0};
   endtask

   task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clock);
      reg_req <= {addr, 8'h00, 1'h0, 1'h1};
      @(posedge clock);
      reg_req <= {~addr, 8'hff, 1'h0, 1'h0};
      @(posedge clock);
      data = reg_rdata;
   endtask

   // service order: top first, then each converter register, then write back the ones seen
   task automatic ack_all();
      logic [7:0] top;
      logic [7:0] c01;
      logic [7:0] c23;
      reg_read(PIF_ADDR_TOP, top);
      reg_read(PIF_ADDR_C01, c01);
      reg_read(PIF_ADDR_C23, c23);
      reg_write(PIF_ADDR_C01, c01);
      reg_write(PIF_ADDR_C23, c23);
      reg_write(PIF_ADDR_TOP, top);
   endtask
endmodule

// ===== verilog/pif_conv_pair.sv
// flag register of one pair of converters with short-circuit timeout
`timescale 1ns/1ns
module pif_conv_pair import pif_pkg::*; #(
   parameter int TIMEOUT_CYC = PIF_SC_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   input wire logic soft_clr,
   // converter state, already synchronised
   input wire logic [1:0] en,
   input wire logic [1:0] pg,
   input wire logic [1:0] above_sc,
   input wire logic [1:0] ilim,
   // register write
   input wire logic wr,
   input wire logic [7:0] wdata,
   // flag register and summaries
   output logic [7:0] flags,
   output logic [1:0] pending
);
   localparam logic [PIF_CNT_W-1:0] LAST = PIF_CNT_W'(TIMEOUT_CYC - 1);

   logic [1:0] risen;
   logic [1:0] timed_out;
   logic [PIF_CNT_W-1:0] cnt [2];
   logic [7:0] set;

   // ramp supervision: count from enable until the output passes the short level
   for (genvar i = 0; i < 2; i++) begin : g_cv
      always_ff @(posedge clock) begin
         if (!rst_b || !en[i]) begin
            risen[i] <= 1'b0;
            cnt[i] <= '0;
         end else begin
            if (above_sc[i]) begin
               risen[i] <= 1'b1;
            end
            if (!risen[i] && !above_sc[i] && cnt[i] != LAST) begin
               cnt[i] <= cnt[i] + 1'b1;
            end
         end
      end
      assign timed_out[i] = en[i] && !risen[i] && !above_sc[i] && cnt[i] == LAST;
      always_comb begin
         set[i*PIF_CV_STRIDE + PIF_CV_PG] = pg[i];
         set[i*PIF_CV_STRIDE + PIF_CV_SC] = (en[i] && risen[i] && !above_sc[i]) || timed_out[i];
         set[i*PIF_CV_STRIDE + PIF_CV_ILIM] = ilim[i];
         set[i*PIF_CV_STRIDE + 3] = 1'b0;
      end
      assign pending[i] = |flags[i*PIF_CV_STRIDE +: 3];
   end

   // reserved bits 7 and 3 stay zero
   always_ff @(posedge clock) begin
      if (!rst_b || soft_clr) begin
         flags <= PIF_CV_RESET;
      end else begin
         flags <= pif_w1c(flags, set, wr, wdata) & 8'h77;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b || soft_clr);

   property p_timeout;
      timed_out != 2'h0 |=> (flags[PIF_CV_SC] || !$past(timed_out[0])) &&
         (flags[PIF_CV_STRIDE + PIF_CV_SC] || !$past(timed_out[1]));
   endproperty
   a_timeout: assert property (p_timeout) else $error("short timeout did not set flag");

   property p_drop;
      en[0] && risen[0] && !above_sc[0] |=> flags[PIF_CV_SC];
   endproperty
   a_drop: assert property (p_drop) else $error("output drop did not set short flag");

   property p_hold;
      flags[PIF_CV_STRIDE + PIF_CV_PG] && !(wr && wdata[PIF_CV_STRIDE + PIF_CV_PG]) |=>
         flags[PIF_CV_STRIDE + PIF_CV_PG];
   endproperty
   a_hold: assert property (p_hold) else $error("power-good flag lost without a write");

   property p_ilim;
      ilim[1] |=> flags[PIF_CV_STRIDE + PIF_CV_ILIM];
   endproperty
   a_ilim: assert property (p_ilim) else $error("current limit flag not set");

   c_timeout: cover property (timed_out != 2'h0);
endmodule

// ===== verilog/pif_flags.sv
// latched event flags, startup sequencing and converter enable gating
`timescale 1ns/1ns
module pif_flags import pif_pkg::*; #(
   parameter int SC_TIMEOUT_CYC = PIF_SC_TIMEOUT_CYC,
   parameter int STARTUP_CYC = PIF_STARTUP_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // asynchronous analog and pin inputs
   input wire pif_pins_s pins,
   // same-clock inputs from the sequencer and measurement unit
   input wire logic [3:0] conv_en_req,
   input wire logic meas_done,
   // register access from the serial interface
   input wire pif_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // converter control
   output logic [3:0] conv_en,
   output logic startup_busy
);
   localparam logic [PIF_CNT_W-1:0] BOOT_LAST = PIF_CNT_W'(STARTUP_CYC - 1);

   pif_pins_s sync1;
   pif_pins_s sync2;
   pif_boot_e boot;
   pif_boot_e next_boot;
   logic [PIF_CNT_W-1:0] boot_cnt;
   logic boot_cause;
   logic boot_done;
   logic soft_clr;
   logic software_reset_cmd;
   logic wr_top;
   logic wr_c01;
   logic wr_c23;
   logic [7:0] top_flags;
   logic [7:0] top_set;
   logic [7:0] c01_flags;
   logic [7:0] c23_flags;
   logic [1:0] pend01;
   logic [1:0] pend23;
   logic [3:0] summary;
   logic [7:0] top_view;
   logic [7:0] stat_view;

   // two-stage synchroniser; the first stage feeds only the second
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
      end
   end

   // register write decode
   assign wr_top = reg_req.wr && reg_req.addr == PIF_ADDR_TOP;
   assign wr_c01 = reg_req.wr && reg_req.addr == PIF_ADDR_C01;
   assign wr_c23 = reg_req.wr && reg_req.addr == PIF_ADDR_C23;
   // the software reset bit is a self-clearing pulse, never stored
   assign software_reset_cmd = reg_req.wr && reg_req.addr == PIF_ADDR_RESET && reg_req.wdata[PIF_SWRESET_BIT];

   // startup: any cause restarts the hold; the flag latches when the hold completes
   assign boot_cause = !sync2.reset_pin_n || !sync2.analog_supply_ok || software_reset_cmd;
   assign boot_done = boot == PIF_BOOT_HOLD && !boot_cause && boot_cnt == BOOT_LAST;
   assign soft_clr = boot == PIF_BOOT_HOLD;
   assign startup_busy = soft_clr;

   always_comb begin
      case (boot)
         PIF_BOOT_HOLD: next_boot = boot_done ? PIF_BOOT_RUN : PIF_BOOT_HOLD;
         PIF_BOOT_RUN: next_boot = boot_cause ? PIF_BOOT_HOLD : PIF_BOOT_RUN;
         default: next_boot = PIF_BOOT_HOLD;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         boot <= PIF_BOOT_HOLD;
      end else begin
         boot <= next_boot;
      end
   end

   // hold counter restarts while a cause is present, so startup follows its release
   always_ff @(posedge clock) begin
      if (!rst_b || boot_cause || boot == PIF_BOOT_RUN) begin
         boot_cnt <= '0;
      end else if (boot_cnt != BOOT_LAST) begin
         boot_cnt <= boot_cnt + 1'b1;
      end
   end

   // top flag sources; summary bits are never stored
   always_comb begin
      top_set = 8'h00;
      top_set[PIF_TOP_TSD] = sync2.tsd;
      top_set[PIF_TOP_TWARN] = sync2.twarn;
      top_set[PIF_TOP_RST] = boot_done;
      top_set[PIF_TOP_MEAS] = meas_done && boot == PIF_BOOT_RUN;
   end

   // the reset flag must survive the defaults restore that precedes it
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         top_flags <= PIF_TOP_RESET;
      end else if (soft_clr && !boot_done) begin
         top_flags <= PIF_TOP_RESET;
      end else begin
         top_flags <= pif_w1c(top_flags, top_set, wr_top, reg_req.wdata) & 8'h0f;
      end
   end

   // converter enables: dropped on the cause edge itself, during startup and while shutdown is latched or live
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         conv_en <= 4'h0;
      end else if (soft_clr || boot_cause || top_flags[PIF_TOP_TSD] || sync2.tsd) begin
         conv_en <= 4'h0;
      end else begin
         conv_en <= conv_en_req;
      end
   end

   // the two flag registers share one implementation
   pif_conv_pair #(
      .TIMEOUT_CYC(SC_TIMEOUT_CYC)
   ) u_c01 (
      .clock(clock),
      .rst_b(rst_b),
      .soft_clr(soft_clr),
      .en(conv_en[1:0]),
      .pg(sync2.conv.pg[1:0]),
      .above_sc(sync2.conv.above_sc[1:0]),
      .ilim(sync2.conv.ilim[1:0]),
      .wr(wr_c01),
      .wdata(reg_req.wdata),
      .flags(c01_flags),
      .pending(pend01)
   );

   pif_conv_pair #(
      .TIMEOUT_CYC(SC_TIMEOUT_CYC)
   ) u_c23 (
      .clock(clock),
      .rst_b(rst_b),
      .soft_clr(soft_clr),
      .en(conv_en[3:2]),
      .pg(sync2.conv.pg[3:2]),
      .above_sc(sync2.conv.above_sc[3:2]),
      .ilim(sync2.conv.ilim[3:2]),
      .wr(wr_c23),
      .wdata(reg_req.wdata),
      .flags(c23_flags),
      .pending(pend23)
   );

   assign summary = {pend23, pend01};
   assign top_view = {summary, top_flags[3:0]};
   // live thermal state, unlatched
   always_comb begin
      stat_view = 8'h00;
      stat_view[PIF_STAT_TSD] = sync2.tsd;
      stat_view[PIF_STAT_TWARN] = sync2.twarn;
   end

   // read data is registered; unmapped offsets and the reset register read zero
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            PIF_ADDR_TOP: reg_rdata <= top_view;
            PIF_ADDR_C01: reg_rdata <= c01_flags;
            PIF_ADDR_C23: reg_rdata <= c23_flags;
            PIF_ADDR_STAT: reg_rdata <= stat_view;
            default: reg_rdata <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   // checked through the read path so a broken summary mux shows up
   property p_sum_follow;
      reg_req.rd && reg_req.addr == PIF_ADDR_TOP |=> reg_rdata[7:4] ==
         {|$past(c23_flags[6:4]), |$past(c23_flags[2:0]), |$past(c01_flags[6:4]), |$past(c01_flags[2:0])};
   endproperty
   a_sum_follow: assert property (p_sum_follow) else $error("summary bit disagrees with flags");

   property p_sum_clear;
      $fell(|c01_flags[2:0]) |-> !top_view[PIF_TOP_SUM_LSB] && !$past(reg_req.wr && !wr_c01 && !soft_clr);
   endproperty
   a_sum_clear: assert property (p_sum_clear) else $error("summary stayed or cleared without cause");

   property p_tsd_off;
      sync2.tsd && boot == PIF_BOOT_RUN |=> top_flags[PIF_TOP_TSD] && conv_en == 4'h0;
   endproperty
   a_tsd_off: assert property (p_tsd_off) else $error("shutdown did not latch or stop converters");

   property p_tsd_block;
      top_flags[PIF_TOP_TSD] |-> conv_en == 4'h0;
   endproperty
   a_tsd_block: assert property (p_tsd_block) else $error("converter enabled during shutdown");

   property p_warn;
      sync2.twarn && boot == PIF_BOOT_RUN && !sync2.tsd && !boot_cause && !top_flags[PIF_TOP_TSD] |=>
         top_flags[PIF_TOP_TWARN] && conv_en == $past(conv_en_req);
   endproperty
   a_warn: assert property (p_warn) else $error("warning flag missing or converters touched");

   property p_live;
      reg_req.rd && reg_req.addr == PIF_ADDR_STAT |=>
         reg_rdata[PIF_STAT_TSD] == $past(sync2.tsd) && reg_rdata[PIF_STAT_TWARN] == $past(sync2.twarn);
   endproperty
   a_live: assert property (p_live) else $error("live thermal bits do not follow temperature");

   property p_boot_flag;
      boot == PIF_BOOT_HOLD ##1 boot == PIF_BOOT_RUN |-> top_flags[PIF_TOP_RST];
   endproperty
   a_boot_flag: assert property (p_boot_flag) else $error("reset flag not set after startup");

   property p_restore;
      boot == PIF_BOOT_RUN && boot_cause |=> conv_en == 4'h0 ##1 c01_flags == 8'h00 && c23_flags == 8'h00;
   endproperty
   a_restore: assert property (p_restore) else $error("reset cause did not restore defaults");

   property p_meas;
      meas_done && boot == PIF_BOOT_RUN && !boot_cause |=> top_flags[PIF_TOP_MEAS];
   endproperty
   a_meas: assert property (p_meas) else $error("measurement flag not set");

   property p_w1c;
      wr_top && reg_req.wdata[PIF_TOP_MEAS] && !meas_done && boot == PIF_BOOT_RUN |=> !top_flags[PIF_TOP_MEAS];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

   // any set flag written with zero must still be set afterwards
   property p_w0;
      wr_top && boot == PIF_BOOT_RUN |=>
         ($past(top_flags[3:0] & ~reg_req.wdata[3:0]) & ~top_flags[3:0]) == 4'h0;
   endproperty
   a_w0: assert property (p_w0) else $error("write zero changed a flag");

   // enable gating and startup sequencing
   property p_en_follow;
      boot == PIF_BOOT_RUN && !boot_cause && !sync2.tsd && !top_flags[PIF_TOP_TSD] |=>
         conv_en == $past(conv_en_req);
   endproperty
   a_en_follow: assert property (p_en_follow) else $error("enable request not passed on");

   property p_hold_off;
      boot == PIF_BOOT_HOLD |=>
         conv_en == 4'h0;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("converter enabled during startup");

   property p_cause_off;
      boot_cause |=>
         conv_en == 4'h0;
   endproperty
   a_cause_off: assert property (p_cause_off) else $error("converter still enabled after reset cause");

   property p_hold_clear;
      boot == PIF_BOOT_HOLD && !boot_done |=>
         top_flags == PIF_TOP_RESET && c01_flags == PIF_CV_RESET && c23_flags == PIF_CV_RESET;
   endproperty
   a_hold_clear: assert property (p_hold_clear) else $error("flags not at defaults during startup");

   property p_cause_stay;
      boot_cause |=>
         boot == PIF_BOOT_HOLD;
   endproperty
   a_cause_stay: assert property (p_cause_stay) else $error("left startup while a cause was present");

   property p_boot_wait;
      boot == PIF_BOOT_HOLD && !boot_done |=>
         boot == PIF_BOOT_HOLD;
   endproperty
   a_boot_wait: assert property (p_boot_wait) else $error("startup ended before its hold time");

   // outside startup, latched flags survive everything but a write of one
   property p_tsd_keep;
      top_flags[PIF_TOP_TSD] && boot == PIF_BOOT_RUN && !(wr_top && reg_req.wdata[PIF_TOP_TSD]) |=>
         top_flags[PIF_TOP_TSD];
   endproperty
   a_tsd_keep: assert property (p_tsd_keep) else $error("shutdown flag lost without a write");

   property p_warn_keep;
      top_flags[PIF_TOP_TWARN] && boot == PIF_BOOT_RUN && !(wr_top && reg_req.wdata[PIF_TOP_TWARN]) |=>
         top_flags[PIF_TOP_TWARN];
   endproperty
   a_warn_keep: assert property (p_warn_keep) else $error("warning flag lost without a write");

   property p_rst_keep;
      top_flags[PIF_TOP_RST] && boot == PIF_BOOT_RUN && !(wr_top && reg_req.wdata[PIF_TOP_RST]) |=>
         top_flags[PIF_TOP_RST];
   endproperty
   a_rst_keep: assert property (p_rst_keep) else $error("reset flag lost without a write");

   property p_meas_keep;
      top_flags[PIF_TOP_MEAS] && boot == PIF_BOOT_RUN && !(wr_top && reg_req.wdata[PIF_TOP_MEAS]) |=>
         top_flags[PIF_TOP_MEAS];
   endproperty
   a_meas_keep: assert property (p_meas_keep) else $error("measurement flag lost without a write");

   // a result arriving during startup is dropped with the other defaults
   property p_meas_idle;
      meas_done && boot == PIF_BOOT_HOLD |=>
         !top_flags[PIF_TOP_MEAS];
   endproperty
   a_meas_idle: assert property (p_meas_idle) else $error("measurement flag set during startup");

   c_tsd: cover property (boot == PIF_BOOT_RUN ##1 top_flags[PIF_TOP_TSD]);
   c_boot: cover property (boot == PIF_BOOT_HOLD ##1 boot == PIF_BOOT_RUN);
   c_clear: cover property ($fell(summary[0]));
   c_swreset: cover property (boot == PIF_BOOT_RUN && software_reset_cmd);
endmodule

// ===== verilog/pif_pkg.sv
// constants, carriers and helpers for the power controller event flag logic
package pif_pkg;
   // register offsets
   localparam logic [7:0] PIF_ADDR_RESET = 8'h16;
   localparam logic [7:0] PIF_ADDR_TOP = 8'h18;
   localparam logic [7:0] PIF_ADDR_C01 = 8'h19;
   localparam logic [7:0] PIF_ADDR_C23 = 8'h1a;
   localparam logic [7:0] PIF_ADDR_STAT = 8'h1b;
   // field positions
   localparam int PIF_TOP_SUM_LSB = 4;
   localparam int PIF_TOP_TSD = 3;
   localparam int PIF_TOP_TWARN = 2;
   localparam int PIF_TOP_RST = 1;
   localparam int PIF_TOP_MEAS = 0;
   localparam int PIF_CV_PG = 2;
   localparam int PIF_CV_SC = 1;
   localparam int PIF_CV_ILIM = 0;
   localparam int PIF_CV_STRIDE = 4;
   localparam int PIF_SWRESET_BIT = 0;
   localparam int PIF_STAT_TSD = 1;
   localparam int PIF_STAT_TWARN = 0;
   // values after reset
   localparam logic [7:0] PIF_TOP_RESET = 8'h00;
   localparam logic [7:0] PIF_CV_RESET = 8'h00;
   // timing at a 10 MHz clock
   localparam int PIF_CLK_KHZ = 10000;
   localparam int PIF_SC_TIMEOUT_US = 1000;
   localparam int PIF_STARTUP_US = 100;
   localparam int PIF_SC_TIMEOUT_CYC = (PIF_SC_TIMEOUT_US * PIF_CLK_KHZ) / 1000;
   localparam int PIF_STARTUP_CYC = (PIF_STARTUP_US * PIF_CLK_KHZ) / 1000;
   localparam int PIF_CNT_W = 14;

   typedef enum logic {
      PIF_BOOT_HOLD = 1'b0,
      PIF_BOOT_RUN = 1'b1
   } pif_boot_e;

   // analog comparator outputs of the four converters
   typedef struct packed {
      logic [3:0] pg;
      logic [3:0] above_sc;
      logic [3:0] ilim;
   } pif_conv_evt_s;

   typedef struct packed {
      logic tsd;
      logic twarn;
      logic reset_pin_n;
      logic analog_supply_ok;
      pif_conv_evt_s conv;
   } pif_pins_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pif_reg_req_s;

   // write-one-to-clear update; a set in the same cycle wins over the clear
   function automatic logic [7:0] pif_w1c(input logic [7:0] cur, input logic [7:0] set,
                                          input logic wr, input logic [7:0] wdata);
      logic [7:0] clr;
      clr = wr ? wdata : 8'h00;
      return (cur & ~clr) | set;
   endfunction
endpackage
